// file: serial0_usart.sv
// Serial port 0: sync shift mode and three async modes behind an Avalon-MM slave
// Functional notes
// - Two upper mode bits select mode 0..3
// - Async frames: start, 8/9 data, stop
// - Bit period 12/4 sync, 64/32 mode 2
// - Modes 1,3 baud from timer 1 or 2
// - Mode 1 with qualifier uses timer 1
// - Mode 1 qualifier: receive done needs stop high
// - Modes 2,3 qualifier: ninth bit 0 dropped
// - Receive enable gates reception; mode 0 starts
// - Modes 2,3 send the transmit ninth bit
// - Modes 2,3 capture received ninth bit
// - Mode 1 no qualifier: stop bit stored
// - Mode 0 transmit done after eighth bit
// - Async transmit done after last data bit
// - Mode 0 receive done after eighth bit
// - Mode 1 receive done at stop sample
// - Modes 2,3 receive done at ninth sample
// - Done flags cleared only by software
// - One data address, separate tx/rx buffers
// - Mode 0: tx pin clock, rx pin data
`timescale 1ns/1ps

module serial0_usart
    import serial0_pkg::*;
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    // Avalon-MM slave, byte address
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // System and timer inputs
    input  wire logic              i_idle,
    input  wire logic              i_baud_double,
    input  wire logic              i_timer2_baud_sel,
    input  wire logic              i_timer1_tick,
    input  wire logic              i_timer2_tick,
    // Serial pins
    output logic                   o_txd,
    input  wire logic              i_rxd,
    output logic                   o_rxd,
    output logic                   o_rxd_oe,
    // Interrupt request
    output logic                   o_irq
);

    serial0_s s_ff;
    serial0_s nxt_s;

    // Decoded helpers
    logic [1:0]  mode;
    logic        qual;
    logic        pclk_en;
    logic        src_tick;
    logic [1:0]  samp_div;
    logic        samp_tick;
    logic        use_t2;
    logic        acc_done;
    logic        wr_ctrl;
    logic        wr_data;
    logic [9:0]  word_index;
    logic [3:0]  sync_per;
    logic [3:0]  last_data_idx;
    logic [3:0]  last_frame_idx;
    logic        tx_set;
    logic        rx_set;
    logic [7:0]  new_ctrl;

    // Mode fields from the control register
    assign mode = {s_ff.ctrl[MODE_HI_BIT], s_ff.ctrl[MODE_LO_BIT]};
    assign qual = s_ff.ctrl[QUAL_BIT];
    // Peripheral clock runs with the system clock except in idle
    assign pclk_en = ~i_idle;
    assign word_index = i_avs_address[ADDR_W-1:2];
    assign acc_done = (i_avs_read | i_avs_write) & ~s_ff.waitreq;
    assign wr_ctrl = acc_done & i_avs_write & i_avs_byteenable[0] & (word_index == CTRL_INDEX);
    assign wr_data = acc_done & i_avs_write & i_avs_byteenable[0] & (word_index == DATA_INDEX);
    // Sync period shortens with the qualifier bit
    assign sync_per = qual ? SYNC_PERIOD_FAST : SYNC_PERIOD;
    // Frame lengths: 10 bits in mode 1, 11 in modes 2 and 3
    assign last_data_idx = (mode == MODE_ASYNC8) ? IDX_LAST8 : IDX_NINTH;
    assign last_frame_idx = (mode == MODE_ASYNC8) ? IDX_NINTH : IDX_STOP11;

    // Baud source: timer 2 only if selected and not mode 1 with qualifier
    always_comb begin
        use_t2 = i_timer2_baud_sel;
        if (mode == MODE_ASYNC8 && qual) begin
            use_t2 = 1'b0;
        end
        if (mode == MODE_FIXED9) begin
            src_tick = pclk_en;
            samp_div = i_baud_double ? M2_SAMPLE_DIV_DB : M2_SAMPLE_DIV;
        end else begin
            src_tick = pclk_en & (use_t2 ? i_timer2_tick : i_timer1_tick);
            samp_div = (use_t2 | i_baud_double) ? NO_SAMPLE_DIV : T1_SAMPLE_DIV;
        end
    end

    // Sixteen sample ticks make one async bit
    assign samp_tick = src_tick & (s_ff.pre == samp_div);

    // Next-state logic for bus, transmitter and receiver
    always_comb begin
        nxt_s = s_ff;
        tx_set = 1'b0;
        rx_set = 1'b0;
        new_ctrl = s_ff.ctrl;

        // Sample prescaler
        if (src_tick) begin
            nxt_s.pre = samp_tick ? 2'h0 : s_ff.pre + 2'h1;
        end

        // Bus handshake: one wait cycle, then completion
        if ((i_avs_read | i_avs_write) && s_ff.waitreq) begin
            nxt_s.waitreq = 1'b0;
            nxt_s.rdata = 32'h0000_0000;
            if (word_index == CTRL_INDEX) begin
                nxt_s.rdata[7:0] = s_ff.ctrl;
            end else if (word_index == DATA_INDEX) begin
                nxt_s.rdata[7:0] = s_ff.rx_buf;
            end
        end else begin
            nxt_s.waitreq = 1'b1;
        end

        // Software control write; done flags cleared here by writing zeros
        if (wr_ctrl) begin
            new_ctrl = i_avs_writedata[7:0];
        end

        // Transmitter
        case (s_ff.tx_st)
            TX_IDLE: begin
                if (wr_data && s_ff.rx_st != RX_SYNC) begin
                    nxt_s.tx_idx = IDX_START;
                    nxt_s.tx_ph = 4'h0;
                    nxt_s.sync_div = 4'h0;
                    if (mode == MODE_SYNC) begin
                        nxt_s.tx_sh = {3'h7, i_avs_writedata[7:0]};
                        nxt_s.tx_st = TX_SYNC;
                    end else begin
                        // Start low, data LSB first, ninth or stop, stop high
                        nxt_s.tx_sh = {1'b1,
                                       (mode == MODE_ASYNC8) ? 1'b1 : s_ff.ctrl[TX9_BIT],
                                       i_avs_writedata[7:0], 1'b0};
                        nxt_s.tx_st = TX_ASYNC;
                    end
                end
            end
            TX_ASYNC: begin
                if (samp_tick) begin
                    nxt_s.tx_ph = s_ff.tx_ph + 4'h1;
                    if (s_ff.tx_ph == SAMPLE_LAST) begin
                        nxt_s.tx_sh = {1'b1, s_ff.tx_sh[10:1]};
                        nxt_s.tx_idx = s_ff.tx_idx + 4'h1;
                        // Done flag rises as the stop bit begins
                        if (s_ff.tx_idx == last_data_idx) begin
                            tx_set = 1'b1;
                        end
                        if (s_ff.tx_idx == last_frame_idx) begin
                            nxt_s.tx_st = TX_IDLE;
                        end
                    end
                end
            end
            TX_SYNC: begin
                if (pclk_en) begin
                    nxt_s.sync_div = s_ff.sync_div + 4'h1;
                    if (s_ff.sync_div == sync_per - 4'h1) begin
                        nxt_s.sync_div = 4'h0;
                        nxt_s.tx_sh = {1'b1, s_ff.tx_sh[10:1]};
                        nxt_s.tx_idx = s_ff.tx_idx + 4'h1;
                        if (s_ff.tx_idx == SYNC_LAST_BIT) begin
                            tx_set = 1'b1;
                            nxt_s.tx_st = TX_IDLE;
                        end
                    end
                end
            end
            default: nxt_s.tx_st = TX_IDLE;
        endcase

        // Receiver
        case (s_ff.rx_st)
            RX_IDLE: begin
                if (samp_tick) begin
                    nxt_s.rx_prev = i_rxd;
                end
                // Mode 0 reception starts when software sets the enable
                if (wr_ctrl && mode == MODE_SYNC
                    && new_ctrl[MODE_HI_BIT:MODE_LO_BIT] == MODE_SYNC
                    && new_ctrl[REN_BIT] && !s_ff.ctrl[REN_BIT]
                    && s_ff.tx_st == TX_IDLE && !wr_data) begin
                    nxt_s.rx_st = RX_SYNC;
                    nxt_s.rx_idx = 4'h0;
                    nxt_s.sync_div = 4'h0;
                end else if (mode != MODE_SYNC && s_ff.ctrl[REN_BIT] && samp_tick
                             && s_ff.rx_prev && !i_rxd) begin
                    // Falling edge seen on a sample tick begins a frame
                    nxt_s.rx_st = RX_ASYNC;
                    nxt_s.rx_idx = IDX_START;
                    nxt_s.rx_ph = 4'h1;
                end
            end
            RX_ASYNC: begin
                if (!s_ff.ctrl[REN_BIT] || mode == MODE_SYNC) begin
                    nxt_s.rx_st = RX_IDLE;
                end else if (samp_tick) begin
                    nxt_s.rx_ph = s_ff.rx_ph + 4'h1;
                    nxt_s.rx_prev = i_rxd;
                    if (s_ff.rx_ph == SAMPLE_POINT) begin
                        nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
                        if (s_ff.rx_idx == IDX_START) begin
                            // Glitch rather than start bit: drop it
                            if (i_rxd) begin
                                nxt_s.rx_st = RX_IDLE;
                            end
                        end else begin
                            nxt_s.rx_sh = {i_rxd, s_ff.rx_sh[8:1]};
                        end
                        if (s_ff.rx_idx == IDX_NINTH) begin
                            // Bit 9 is the stop bit in mode 1, ninth data otherwise.
                            // Edge tracking keeps the sampled level: a low ninth or
                            // stop bit must not look like the next start bit.
                            nxt_s.rx_st = RX_IDLE;
                            if (mode == MODE_ASYNC8) begin
                                rx_set = !qual || i_rxd;
                            end else begin
                                rx_set = !qual || i_rxd;
                            end
                        end
                    end
                end
            end
            RX_SYNC: begin
                if (pclk_en) begin
                    nxt_s.sync_div = s_ff.sync_div + 4'h1;
                    // Sample data as the shift clock rises mid-bit
                    if (s_ff.sync_div == (sync_per >> 1)) begin
                        nxt_s.rx_sh = {i_rxd, s_ff.rx_sh[8:1]};
                    end
                    if (s_ff.sync_div == sync_per - 4'h1) begin
                        nxt_s.sync_div = 4'h0;
                        nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
                        if (s_ff.rx_idx == SYNC_LAST_BIT) begin
                            nxt_s.rx_st = RX_IDLE;
                            nxt_s.rx_buf = s_ff.rx_sh[8:1];
                            rx_set = 1'b1;
                        end
                    end
                end
            end
            default: nxt_s.rx_st = RX_IDLE;
        endcase

        // Async frame accepted: load buffer, and ninth bit unless mode 1 with qualifier
        if (rx_set && s_ff.rx_st == RX_ASYNC) begin
            nxt_s.rx_buf = s_ff.rx_sh[8:1];
            if (mode != MODE_ASYNC8) begin
                new_ctrl[RX9_BIT] = i_rxd;
            end else if (!qual) begin
                new_ctrl[RX9_BIT] = i_rxd;
            end
        end

        // Hardware set wins over a software clear in the same cycle
        if (tx_set) begin
            new_ctrl[TXDONE_BIT] = 1'b1;
        end
        if (rx_set) begin
            new_ctrl[RXDONE_BIT] = 1'b1;
        end
        nxt_s.ctrl = new_ctrl;

        // Pin drive from the next state so outputs have no extra lag
        nxt_s.rxd_oe = (nxt_s.tx_st == TX_SYNC);
        nxt_s.rxd_o = (nxt_s.tx_st == TX_SYNC) ? nxt_s.tx_sh[0] : 1'b1;
        if (nxt_s.tx_st == TX_ASYNC) begin
            nxt_s.txd = nxt_s.tx_sh[0];
        end else if (nxt_s.tx_st == TX_SYNC || nxt_s.rx_st == RX_SYNC) begin
            // Shift clock low in the first half of each bit
            nxt_s.txd = (nxt_s.sync_div >= (sync_per >> 1));
        end else begin
            nxt_s.txd = 1'b1;
        end
        nxt_s.irq = nxt_s.ctrl[TXDONE_BIT] | nxt_s.ctrl[RXDONE_BIT];
    end

    // State register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s_ff <= '{tx_st: TX_IDLE, rx_st: RX_IDLE, ctrl: CTRL_RESET,
                      rx_buf: DATA_RESET, tx_sh: 11'h7FF, tx_idx: 4'h0,
                      tx_ph: 4'h0, rx_sh: 9'h000, rx_idx: 4'h0, rx_ph: 4'h0,
                      rx_prev: 1'b1, sync_div: 4'h0, pre: 2'h0, txd: 1'b1,
                      rxd_o: 1'b1, rxd_oe: 1'b0, irq: 1'b0, waitreq: 1'b1,
                      rdata: 32'h0000_0000};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign o_avs_readdata    = s_ff.rdata;
    assign o_avs_waitrequest = s_ff.waitreq;
    assign o_txd             = s_ff.txd;
    assign o_rxd             = s_ff.rxd_o;
    assign o_rxd_oe          = s_ff.rxd_oe;
    assign o_irq             = s_ff.irq;

endmodule

// file: serial0_pkg.sv
// Constants and types shared by the serial port 0 block
package serial0_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  CTRL_INDEX       = 10'h098;
    localparam logic [9:0]  DATA_INDEX       = 10'h099;
    localparam int          ADDR_W           = 12;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [7:0]  DATA_RESET       = 8'h00;

    // Control register bit positions
    localparam int          MODE_HI_BIT      = 7;
    localparam int          MODE_LO_BIT      = 6;
    localparam int          QUAL_BIT         = 5;
    localparam int          REN_BIT          = 4;
    localparam int          TX9_BIT          = 3;
    localparam int          RX9_BIT          = 2;
    localparam int          TXDONE_BIT       = 1;
    localparam int          RXDONE_BIT       = 0;

    // Serial modes
    localparam logic [1:0]  MODE_SYNC        = 2'h0;
    localparam logic [1:0]  MODE_ASYNC8      = 2'h1;
    localparam logic [1:0]  MODE_FIXED9      = 2'h2;
    localparam logic [1:0]  MODE_TIMER9      = 2'h3;

    // Bit timing in peripheral clocks and sample ticks
    localparam logic [3:0]  SYNC_PERIOD      = 4'hC;
    localparam logic [3:0]  SYNC_PERIOD_FAST = 4'h4;
    localparam logic [1:0]  M2_SAMPLE_DIV    = 2'h3;
    localparam logic [1:0]  M2_SAMPLE_DIV_DB = 2'h1;
    localparam logic [1:0]  T1_SAMPLE_DIV    = 2'h1;
    localparam logic [1:0]  NO_SAMPLE_DIV    = 2'h0;
    localparam logic [3:0]  SAMPLE_LAST      = 4'hF;
    localparam logic [3:0]  SAMPLE_POINT     = 4'h7;
    localparam logic [3:0]  SYNC_LAST_BIT    = 4'h7;

    // Frame bit indices: 0 start, 1..8 data, 9 ninth or stop, 10 stop
    localparam logic [3:0]  IDX_START        = 4'h0;
    localparam logic [3:0]  IDX_NINTH        = 4'h9;
    localparam logic [3:0]  IDX_LAST8        = 4'h8;
    localparam logic [3:0]  IDX_STOP11       = 4'hA;

    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} rx_state_e;

    typedef struct packed {
        tx_state_e   tx_st;
        rx_state_e   rx_st;
        logic [7:0]  ctrl;
        logic [7:0]  rx_buf;
        logic [10:0] tx_sh;
        logic [3:0]  tx_idx;
        logic [3:0]  tx_ph;
        logic [8:0]  rx_sh;
        logic [3:0]  rx_idx;
        logic [3:0]  rx_ph;
        logic        rx_prev;
        logic [3:0]  sync_div;
        logic [1:0]  pre;
        logic        txd;
        logic        rxd_o;
        logic        rxd_oe;
        logic        irq;
        logic        waitreq;
        logic [31:0] rdata;
    } serial0_s;

endpackage

// file: serial0_usart_assertions.sv
// Port-level checker for serial port 0
`timescale 1ns/1ps

module serial0_usart_assertions
    import serial0_pkg::*;
(
    // Clock, reset and register bus
    input wire logic              i_ref_clk,
    input wire logic              i_rst,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [31:0]       i_avs_writedata,
    input wire logic [3:0]        i_avs_byteenable,
    input wire logic [31:0]       o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    // Idle, pins and interrupt
    input wire logic              i_idle,
    input wire logic              o_txd,
    input wire logic              o_rxd,
    input wire logic              o_rxd_oe,
    input wire logic              o_irq
);
    logic [1:0] mode_ff;

    // Mirror of the mode bits, so pin checks know which mode is active
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_ff <= 2'h0;
        end else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                     && i_avs_address[11:2] == CTRL_INDEX) begin
            mode_ff <= i_avs_writedata[7:6];
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    // Bus access in two steps: request seen, then one cycle of answer
    sequence s_request;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_answer;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    a_wait_answer: assert property (s_request |=> s_answer)
        else $error("waitrequest answer not one cycle after request");
    a_wait_idle: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> o_avs_waitrequest)
        else $error("waitrequest dropped with no request");
    a_reset_values: assert property ($fell(i_rst) |-> o_avs_waitrequest && o_txd
        && o_rxd && !o_rxd_oe && !o_irq)
        else $error("outputs not at reset level after release");
    a_idle_freeze: assert property (i_idle && !i_avs_write |=> $stable(o_txd)
        && $stable(o_rxd) && $stable(o_rxd_oe))
        else $error("serial pins moved while peripheral clock halted");
    a_data_released: assert property (!o_rxd_oe |-> o_rxd)
        else $error("receive pin data not high while undriven");
    a_drive_mode0: assert property (o_rxd_oe |-> mode_ff == MODE_SYNC)
        else $error("receive pin driven outside mode 0");
    a_irq_swclear: assert property ($fell(o_irq)
        |-> $past(i_avs_write) || $past(i_avs_write, 2))
        else $error("interrupt dropped without a software write");
    a_unmapped_zero: assert property (!o_avs_waitrequest && i_avs_read
        && i_avs_address[11:2] != CTRL_INDEX && i_avs_address[11:2] != DATA_INDEX
        |-> o_avs_readdata == 32'h0)
        else $error("unmapped read returned nonzero");
    a_rdata_upper: assert property (o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
endmodule

bind serial0_usart serial0_usart_assertions chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_idle(i_idle), .o_txd(o_txd), .o_rxd(o_rxd),
    .o_rxd_oe(o_rxd_oe), .o_irq(o_irq)
);

// file: serial0_far_end.sv
// Far end: async transmitter or mode 0 shift register driving the receive pin
`timescale 1ns/1ps

module serial0_far_end (
    // Clock in, line out
    input  wire logic i_ref_clk,
    input  wire logic i_shift_clk,
    output logic      o_line
);
    // Line idles at mark level between frames
    initial o_line = 1'b1;

    // One frame: start low, data LSB first, chosen stop level, per cycles a bit
    task automatic send(input logic [8:0] d, input int nb, input logic stop, input int per);
        o_line <= 1'b0;
        repeat (per) @(posedge i_ref_clk);
        for (int i = 0; i < nb; i++) begin
            o_line <= d[i];
            repeat (per) @(posedge i_ref_clk);
        end
        o_line <= stop;
        repeat (per) @(posedge i_ref_clk);
        o_line <= 1'b1;
    endtask

    // Mode 0 peripheral: next bit after each shift clock fall, last one held past its rise
    task automatic shift_out(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge i_shift_clk);
            o_line <= d[i];
        end
        @(posedge i_shift_clk);
        repeat (2) @(posedge i_ref_clk);
        o_line <= 1'b1;
    endtask
endmodule

// file: serial0_usart_tb.sv
// Self-checking bench for serial port 0
`timescale 1ns/1ps

module serial0_usart_tb;
    import serial0_pkg::*;
    localparam logic [11:0] A_CTRL = 12'h260, A_DATA = 12'h264, A_NONE = 12'h010;
    logic              i_ref_clk = 1'b0, i_rst = 1'b1;
    logic [ADDR_W-1:0] i_avs_address = '0;
    logic              i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [31:0]       i_avs_writedata = '0, o_avs_readdata;
    logic [3:0]        i_avs_byteenable = 4'h1;
    logic              i_idle = 1'b0, i_baud_double = 1'b0, i_timer2_baud_sel = 1'b0;
    logic              i_timer1_tick = 1'b0, i_timer2_tick = 1'b1;
    logic              o_avs_waitrequest, o_txd, o_rxd, o_rxd_oe, o_irq, far_line, rx_pin;
    logic [1:0]        t1_cnt = 2'h0;
    int                cyc = 0, errors = 0, n_tests = 0;

    // Receive pin: device drives it in mode 0 transmit, else the far end
    assign rx_pin = o_rxd_oe ? o_rxd : far_line;

    // 20 MHz clock
    always #25 i_ref_clk = ~i_ref_clk;

    // Timer 1 overflows every 4 clocks; timer 2 stays high, a tick each clock
    always @(posedge i_ref_clk) begin
        t1_cnt <= t1_cnt + 2'h1;
        i_timer1_tick <= (t1_cnt == 2'h3);
        cyc <= cyc + 1;
    end

    serial0_usart dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_idle(i_idle), .i_baud_double(i_baud_double),
        .i_timer2_baud_sel(i_timer2_baud_sel), .i_timer1_tick(i_timer1_tick),
        .i_timer2_tick(i_timer2_tick), .o_txd(o_txd), .i_rxd(rx_pin), .o_rxd(o_rxd),
        .o_rxd_oe(o_rxd_oe), .o_irq(o_irq)
    );
    serial0_far_end far (.i_ref_clk(i_ref_clk), .i_shift_clk(o_txd), .o_line(far_line));

    task automatic final_report();
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Hold the request until waitrequest is sampled low; a stuck slave counts
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_write <= w;
        i_avs_read <= !w;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) errors++;
        q = o_avs_readdata[7:0];
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check("register read", q & m, exp);
    endtask

    // Reset values, unmapped place, refused byte lane
    task automatic t_regs();
        rd(A_CTRL, 8'h00, 8'hFF);
        rd(A_DATA, 8'h00, 8'hFF);
        wr(A_NONE, 8'hFF);
        rd(A_NONE, 8'h00, 8'hFF);
        i_avs_byteenable <= 4'h0;
        wr(A_CTRL, 8'hF0);
        i_avs_byteenable <= 4'h1;
        rd(A_CTRL, 8'h00, 8'hFF);
    endtask

    // Mode 2 frame at bit centres, with an optional idle stall in the start bit
    task automatic t_async_tx(input logic [7:0] ctl, input logic dbl, input int per,
                              input logic [7:0] d, input int stall);
        logic [10:0] exp;
        int          n;
        exp = {1'b1, ctl[TX9_BIT], d, 1'b0};
        n = 0;
        i_baud_double <= dbl;
        wr(A_CTRL, ctl);
        wr(A_DATA, d);
        while (o_txd !== 1'b0 && n < 200) begin
            @(posedge i_ref_clk);
            n++;
        end
        if (stall > 0) begin
            i_idle <= 1'b1;
            repeat (stall) @(posedge i_ref_clk);
            i_idle <= 1'b0;
        end
        repeat (per / 2) @(posedge i_ref_clk);
        for (int i = 0; i < 11; i++) begin
            check("txd bit", o_txd, exp[i]);
            check("irq", o_irq, i == 10);
            repeat (per) @(posedge i_ref_clk);
        end
        repeat (100) @(posedge i_ref_clk);
        check("irq held", o_irq, 1'b1);
        rd(A_CTRL, ctl | 8'h02, 8'hFF);
        wr(A_CTRL, ctl);
        repeat (3) @(posedge i_ref_clk);
        check("irq cleared", o_irq, 1'b0);
    endtask

    // Mode 0 transmit: data on the receive pin at each shift clock rise
    task automatic t_sync_tx(input logic [7:0] ctl, input int per, input logic [7:0] d);
        logic [7:0] got;
        int         n, t0;
        wr(A_CTRL, ctl);
        wr(A_DATA, d);
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (o_txd !== 1'b0 && n < 100) begin
                @(posedge i_ref_clk);
                n++;
            end
            while (o_txd !== 1'b1 && n < 100) begin
                @(posedge i_ref_clk);
                n++;
            end
            got[i] = o_rxd;
            check("drive enable", o_rxd_oe, 1'b1);
            if (i == 0) t0 = cyc;
        end
        check("shift period", cyc - t0, 7 * per);
        check("shift data", got, d);
        repeat (per) @(posedge i_ref_clk);
        rd(A_CTRL, ctl | 8'h02, 8'hFF);
        wr(A_CTRL, ctl);
    endtask

    // Mode 0 receive: enable rising from 0 to 1 starts one byte from the far end
    task automatic t_sync_rx(input logic [7:0] d);
        wr(A_CTRL, 8'h00);
        fork
            far.shift_out(d);
            wr(A_CTRL, 8'h10);
        join
        repeat (24) @(posedge i_ref_clk);
        rd(A_CTRL, 8'h11, 8'hFF);
        rd(A_DATA, d, 8'hFF);
        wr(A_CTRL, 8'h00);
    endtask

    // Far end sends one frame; flags and buffer judged afterwards
    task automatic t_rx(input logic [7:0] ctl, input logic sel, input int per,
                        input logic [8:0] d, input int nb, input logic stop,
                        input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] q;
        // Earlier transmit scenarios may leave the doubler on; far end timing assumes it off
        i_baud_double <= 1'b0;
        i_timer2_baud_sel <= sel;
        wr(A_CTRL, ctl);
        far.send(d, nb, stop, per);
        repeat (8) @(posedge i_ref_clk);
        rd(A_CTRL, exp, m);
        if (exp[RXDONE_BIT]) begin
            bus(1'b0, A_DATA, 8'h00, q);
            check("rx data", q, d[7:0]);
        end
        wr(A_CTRL, ctl);
    endtask

    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        t_regs();
        t_async_tx(8'h88, 1'b0, 64, 8'hA5, 0);
        t_async_tx(8'h80, 1'b1, 32, 8'h3C, 40);
        t_sync_tx(8'h00, 12, 8'h96);
        t_sync_tx(8'h20, 4, 8'h69);
        t_sync_rx(8'hC6);
        t_rx(8'h90, 1'b0, 64, 9'h15A, 9, 1'b1, 8'hFF, 8'h95);
        t_rx(8'hB0, 1'b0, 64, 9'h05A, 9, 1'b1, 8'hFF, 8'hB0);
        t_rx(8'hB0, 1'b0, 64, 9'h1C3, 9, 1'b1, 8'hFF, 8'hB5);
        t_rx(8'h80, 1'b0, 64, 9'h15A, 9, 1'b1, 8'hFF, 8'h80);
        t_rx(8'h50, 1'b1, 16, 9'h0E7, 8, 1'b1, 8'hFF, 8'h55);
        t_rx(8'h70, 1'b1, 128, 9'h0E7, 8, 1'b0, 8'hFF, 8'h70);
        t_rx(8'h70, 1'b1, 128, 9'h081, 8, 1'b1, 8'hFB, 8'h71);
        t_rx(8'hD0, 1'b0, 128, 9'h1AA, 9, 1'b1, 8'hFF, 8'hD5);
        final_report();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        errors++;
        final_report();
    end
endmodule
